//--- inc/romc_map.svh
// Constants of the reader operating mode control block
`ifndef ROMC_MAP_SVH
`define ROMC_MAP_SVH

// ==========================================================
// Operation control word
`define ROMC_OPCTL_RESET   8'h00
`define ROMC_BIT_EN        7
`define ROMC_BIT_RX_EN     6
`define ROMC_BIT_TX_EN     3
`define ROMC_BIT_LOW_POWER_DETECT_SEL 2

// ==========================================================
// Timing
`define ROMC_CLK_NS        40
`define ROMC_OSC_FILT_NS   1000
`define ROMC_OSC_FILT_CYC  ((`ROMC_OSC_FILT_NS + `ROMC_CLK_NS - 1) / `ROMC_CLK_NS)
`define ROMC_REG_SETTLE_NS 2000
`define ROMC_REG_SETTLE_CYC ((`ROMC_REG_SETTLE_NS + `ROMC_CLK_NS - 1) / `ROMC_CLK_NS)
`define ROMC_WAKE_BASE_NS  100000
`define ROMC_WAKE_BASE_CYC (`ROMC_WAKE_BASE_NS / `ROMC_CLK_NS)

// ==========================================================
// Regulator
`define ROMC_REG_DROP_MV   250
`define ROMC_VDD_LSB_MV    10
`define ROMC_REG_DROP_CODE (`ROMC_REG_DROP_MV / `ROMC_VDD_LSB_MV)

// ==========================================================
// Host clock output select
`define ROMC_MCU_CLK_OFF   2'h0

`endif

//--- inc/romc_pkg.sv
// Types of the reader operating mode control block
package romc_pkg;

  typedef enum logic [1:0] {
    ROMC_POWER_DOWN,
    ROMC_READY,
    ROMC_WAKE_UP,
    ROMC_ACTIVE
  } romc_mode_e;

  typedef enum logic [1:0] {
    ROMC_OSC_OFF,
    ROMC_OSC_START,
    ROMC_OSC_STABLE
  } romc_osc_e;

  typedef enum logic [1:0] {
    ROMC_ADJ_IDLE,
    ROMC_ADJ_LOAD,
    ROMC_ADJ_STORE
  } romc_adj_e;

endpackage

//--- rtl/romc_wake_timer.sv
// Periodic wake-up timer for low power presence checks
`timescale 1ns/1ps
module romc_wake_timer #(
  parameter int BASE_CYC = 2500
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       en_i,
  input  wire logic [2:0] period_sel_i,
  output logic            tick_o
);
  import romc_pkg::*;

  // ==========================================================
  // Period decode
  logic [23:0] cnt;
  wire  [23:0] limit   = 24'(BASE_CYC) << period_sel_i;
  wire         at_end  = (cnt >= limit - 24'h000001);

  // ==========================================================
  // Counter
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !en_i) begin
      cnt    <= 24'h000000;
      tick_o <= 1'b0;
    end else begin
      cnt    <= at_end ? 24'h000000 : cnt + 24'h000001;
      tick_o <= at_end;
    end
  end

endmodule // romc_wake_timer

//--- rtl/romc_ctrl.sv
// Operating mode control of the reader front end
`timescale 1ns/1ps
`include "romc_map.svh"
module romc_ctrl #(
  parameter int WAKE_BASE_CYC = `ROMC_WAKE_BASE_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 supply_low_i,
  input  wire logic                 opctl_wr_i,
  input  wire logic [7:0]           opctl_data_i,
  output logic [7:0]                opctl_o,
  output romc_pkg::romc_mode_e      mode_o,
  output logic                      osc_en_o,
  output logic                      osc_gm_boost_o,
  output logic                      reg_en_o,
  output logic                      rx_en_o,
  output logic                      tx_en_o,
  input  wire logic                 osc_ampl_ok_i,
  output logic                      osc_irq_o,
  input  wire logic                 osc_irq_clr_i,
  output logic                      wake_irq_o,
  input  wire logic                 wake_irq_clr_i,
  input  wire logic [2:0]           wake_period_i,
  input  wire logic                 cal_i,
  input  wire logic [7:0]           sense_thresh_i,
  output logic                      meas_start_o,
  output logic                      sense_patch_out_o,
  input  wire logic                 meas_done_i,
  input  wire logic [7:0]           meas_value_i,
  output logic [7:0]                ref_o,
  input  wire logic                 reg_adjust_i,
  input  wire logic [7:0]           vdd_level_i,
  output logic                      reg_max_load_o,
  output logic                      reg_busy_o,
  input  wire logic                 reg_manual_wr_i,
  input  wire logic [7:0]           reg_manual_val_i,
  output logic [7:0]                reg_ref_o,
  output logic [7:0]                reg_display_o,
  input  wire logic [1:0]           mcu_clk_sel_i,
  output logic                      mcu_clk_o,
  input  wire logic                 xtal_27m_i,
  output logic                      very_high_rate_operation_ok_o
);
  import romc_pkg::*;

  // ==========================================================
  // Pin synchronisers
  wire  [2:0] pin_raw = {xtal_27m_i, osc_ampl_ok_i, supply_low_i};
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        pin_meta[g] <= pin_raw[g];
        pin_sync[g] <= pin_meta[g];
      end
    end
  endgenerate
  wire supply_low_s = pin_sync[0];
  wire ampl_ok_s    = pin_sync[1];
  wire xtal_27m_s   = pin_sync[2];

  // Internal reset from pin and low supply
  wire rst_n = resetn_i & ~supply_low_s;

  // ==========================================================
  // Operation control word
  localparam logic [7:0] WAKE_ONLY = 8'h01 << `ROMC_BIT_LOW_POWER_DETECT_SEL;
  wire wake_only = (opctl_o == WAKE_ONLY);
  wire en_bit   = opctl_o[`ROMC_BIT_EN];

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      opctl_o <= `ROMC_OPCTL_RESET;
    end else if (opctl_wr_i) begin
      opctl_o <= opctl_data_i;
    end
  end

  assign osc_en_o = en_bit;
  assign reg_en_o = en_bit;
  assign rx_en_o  = opctl_o[`ROMC_BIT_RX_EN];
  assign tx_en_o  = opctl_o[`ROMC_BIT_TX_EN];
  assign mode_o   = wake_only ? ROMC_WAKE_UP :
                    (rx_en_o | tx_en_o) ? ROMC_ACTIVE :
                    en_bit ? ROMC_READY : ROMC_POWER_DOWN;

  // ==========================================================
  // Oscillator start-up
  romc_osc_e osc_state;
  romc_osc_e next_osc_state;
  logic [5:0] filt_cnt;
  wire filt_done = (filt_cnt == 6'(`ROMC_OSC_FILT_CYC - 1)) && ampl_ok_s;
  wire osc_stable = (osc_state == ROMC_OSC_STABLE);

  always_comb begin
    case (osc_state)
      ROMC_OSC_OFF:    next_osc_state = en_bit ? ROMC_OSC_START : ROMC_OSC_OFF;
      ROMC_OSC_START:  next_osc_state = !en_bit ? ROMC_OSC_OFF :
                                        filt_done ? ROMC_OSC_STABLE : ROMC_OSC_START;
      ROMC_OSC_STABLE: next_osc_state = en_bit ? ROMC_OSC_STABLE : ROMC_OSC_OFF;
      default:         next_osc_state = ROMC_OSC_OFF;
    endcase
  end

  wire osc_set = (osc_state == ROMC_OSC_START) && filt_done && en_bit;
  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      osc_state <= ROMC_OSC_OFF;
      filt_cnt  <= 6'h00;
      osc_irq_o <= 1'b0;
    end else begin
      osc_state <= next_osc_state;
      filt_cnt  <= (osc_state == ROMC_OSC_START && ampl_ok_s && !filt_done) ?
                   filt_cnt + 6'h01 : 6'h00;
      osc_irq_o <= osc_set | (osc_irq_o & ~osc_irq_clr_i);
    end
  end

  assign osc_gm_boost_o = (osc_state == ROMC_OSC_START);

  // ==========================================================
  // Wake-up measurements
  logic       wake_tick;
  logic       meas_busy;
  logic       cal_pend;
  wire  [7:0] diff     = (meas_value_i >= ref_o) ? meas_value_i - ref_o
                                                 : ref_o - meas_value_i;
  wire        got_meas = meas_done_i && meas_busy && wake_only;
  wire        wake_set = got_meas && !cal_pend && (diff > sense_thresh_i);

  romc_wake_timer #(
    .BASE_CYC     (WAKE_BASE_CYC)
  ) u_timer (
    .clk_i        (clk_i),
    .resetn_i     (rst_n),
    .en_i         (wake_only),
    .period_sel_i (wake_period_i),
    .tick_o       (wake_tick)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      meas_busy    <= 1'b0;
      meas_start_o <= 1'b0;
      cal_pend     <= 1'b0;
      ref_o        <= 8'h00;
      wake_irq_o   <= 1'b0;
    end else begin
      meas_start_o <= wake_only && wake_tick && !meas_busy;
      if (!wake_only) begin
        meas_busy <= 1'b0;
      end else if (wake_tick && !meas_busy) begin
        meas_busy <= 1'b1;
      end else if (got_meas) begin
        meas_busy <= 1'b0;
      end
      if (got_meas && cal_pend) begin
        cal_pend <= 1'b0;
        ref_o    <= meas_value_i;
      end else if (cal_i) begin
        cal_pend <= 1'b1;
      end
      wake_irq_o <= wake_set | (wake_irq_o & ~wake_irq_clr_i);
    end
  end

  assign sense_patch_out_o = meas_busy;

  // ==========================================================
  // Regulator adjust
  romc_adj_e  adj_state;
  romc_adj_e  next_adj_state;
  logic [5:0] settle_cnt;
  wire settled = (settle_cnt == 6'(`ROMC_REG_SETTLE_CYC - 1));
  localparam logic [7:0] DROP = 8'(`ROMC_REG_DROP_CODE);
  wire [7:0] adj_result = (vdd_level_i > DROP) ? vdd_level_i - DROP : 8'h00;

  always_comb begin
    case (adj_state)
      ROMC_ADJ_IDLE:  next_adj_state = reg_adjust_i ? ROMC_ADJ_LOAD : ROMC_ADJ_IDLE;
      ROMC_ADJ_LOAD:  next_adj_state = settled ? ROMC_ADJ_STORE : ROMC_ADJ_LOAD;
      ROMC_ADJ_STORE: next_adj_state = ROMC_ADJ_IDLE;
      default:        next_adj_state = ROMC_ADJ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      adj_state     <= ROMC_ADJ_IDLE;
      settle_cnt    <= 6'h00;
      reg_ref_o     <= 8'h00;
      reg_display_o <= 8'h00;
    end else begin
      adj_state  <= next_adj_state;
      settle_cnt <= (adj_state == ROMC_ADJ_LOAD) ? settle_cnt + 6'h01 : 6'h00;
      if (adj_state == ROMC_ADJ_STORE) begin
        reg_ref_o     <= adj_result;
        reg_display_o <= adj_result;
      end else if (adj_state == ROMC_ADJ_IDLE && reg_manual_wr_i && !reg_adjust_i) begin
        reg_ref_o     <= reg_manual_val_i;
        reg_display_o <= reg_manual_val_i;
      end
    end
  end

  assign reg_max_load_o = (adj_state != ROMC_ADJ_IDLE);
  assign reg_busy_o     = reg_max_load_o;

  // ==========================================================
  // Host clock output and crystal check
  logic [2:0] clk_div;
  wire clk_run = osc_stable && (mcu_clk_sel_i != `ROMC_MCU_CLK_OFF);
  wire clk_bit = clk_div[mcu_clk_sel_i - 2'h1];

  always_ff @(posedge clk_i) begin
    if (!rst_n) begin
      clk_div   <= 3'h0;
      mcu_clk_o <= 1'b0;
      very_high_rate_operation_ok_o <= 1'b0;
    end else begin
      clk_div   <= clk_run ? clk_div + 3'h1 : 3'h0;
      mcu_clk_o <= clk_run & clk_bit;
      very_high_rate_operation_ok_o <= xtal_27m_s;
    end
  end

  // ==========================================================
  // Assertions
  a_reset_clears_word: assert property (@(posedge clk_i)
    $rose(rst_n) |-> (opctl_o == 8'h00) && !osc_en_o && !rx_en_o && !tx_en_o)
    else $error("Control word not cleared by reset");
  a_write_takes_data: assert property (@(posedge clk_i) disable iff (!rst_n)
    opctl_wr_i |=> opctl_o == $past(opctl_data_i))
    else $error("Control word write lost");
  a_ready_enables_osc: assert property (@(posedge clk_i) disable iff (!rst_n)
    en_bit |-> osc_en_o && reg_en_o && (mode_o != ROMC_POWER_DOWN))
    else $error("Ready mode without oscillator");
  a_osc_stable_irq: assert property (@(posedge clk_i) disable iff (!rst_n)
    osc_set |=> osc_irq_o && !osc_gm_boost_o)
    else $error("Oscillator stable interrupt missing");
  a_rx_tx_split: assert property (@(posedge clk_i) disable iff (!rst_n)
    (rx_en_o == opctl_o[`ROMC_BIT_RX_EN]) && (tx_en_o == opctl_o[`ROMC_BIT_TX_EN]))
    else $error("Receiver or transmitter enable wrong");
  a_meas_only_wake: assert property (@(posedge clk_i) disable iff (!rst_n)
    meas_start_o |-> $past(wake_only) && $past(wake_tick))
    else $error("Measurement outside wake-up mode");
  a_wake_irq_set: assert property (@(posedge clk_i) disable iff (!rst_n)
    wake_set |=> wake_irq_o)
    else $error("Wake interrupt missing");
  a_cal_ref_store: assert property (@(posedge clk_i) disable iff (!rst_n)
    (got_meas && cal_pend) |=> (ref_o == $past(meas_value_i)) && !$rose(wake_irq_o))
    else $error("Reference not stored");
  a_adjust_drop: assert property (@(posedge clk_i) disable iff (!rst_n)
    (adj_state == ROMC_ADJ_IDLE && reg_adjust_i) |=> reg_max_load_o [*2])
    else $error("Full load not applied for adjust");
  a_adjust_value: assert property (@(posedge clk_i) disable iff (!rst_n)
    (adj_state == ROMC_ADJ_STORE) |=> reg_ref_o == $past(adj_result))
    else $error("Adjusted reference wrong");
  a_manual_reg: assert property (@(posedge clk_i) disable iff (!rst_n)
    (adj_state == ROMC_ADJ_IDLE && reg_manual_wr_i && !reg_adjust_i)
      |=> reg_ref_o == $past(reg_manual_val_i))
    else $error("Manual regulator value not applied");
  a_mcu_clk_off: assert property (@(posedge clk_i) disable iff (!rst_n)
    !clk_run |=> !mcu_clk_o)
    else $error("Host clock running while off");
  a_low_supply_rst: assert property (@(posedge clk_i) disable iff (!resetn_i)
    supply_low_s |=> opctl_o == 8'h00)
    else $error("Low supply did not reset");
  a_wake_stop: assert property (@(posedge clk_i) disable iff (!rst_n)
    !wake_only |=> !meas_busy && !meas_start_o)
    else $error("Measurement continues after wake-up mode");

endmodule // romc_ctrl

//--- testbench/romc_meas_model.sv
// Measurement front end model answering presence measurement requests
`timescale 1ns/1ps
module romc_meas_model #(
  parameter int DELAY = 3
) (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [7:0] value_i,
  output logic            done_o,
  output logic [7:0]      value_o
);
  int cnt = 0;
  initial begin
    done_o  = 1'b0;
    value_o = 8'h5a;
  end
  // ==========================================================
  // Answer each request after DELAY cycles, value not held outside
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    value_o <= ~value_o;
    if (start_i) begin
      cnt <= DELAY;
    end else if (cnt == 1) begin
      done_o  <= 1'b1;
      value_o <= value_i;
      cnt     <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule // romc_meas_model

//--- testbench/test_romc_ctrl.sv
// Self-checking testbench of the operating mode control block
`timescale 1ns/1ps
module test_romc_ctrl;
  import romc_pkg::*;
  logic clk_i = 0, resetn_i = 0, supply_low_i = 0, opctl_wr_i = 0, osc_ampl_ok_i = 0;
  logic osc_irq_clr_i = 0, wake_irq_clr_i = 0, cal_i = 0, meas_done_i, reg_adjust_i = 0;
  logic reg_manual_wr_i = 0, xtal_27m_i = 0;
  logic [7:0] opctl_data_i = 0, sense_thresh_i = 8'h10, meas_value_i, vdd_level_i = 8'h80;
  logic [7:0] reg_manual_val_i = 0, mval = 8'h30, opctl_o, ref_o, reg_ref_o, reg_display_o;
  logic [2:0] wake_period_i = 0;
  logic [1:0] mcu_clk_sel_i = 0;
  logic osc_en_o, osc_gm_boost_o, reg_en_o, rx_en_o, tx_en_o, osc_irq_o, wake_irq_o;
  logic meas_start_o, sense_patch_out_o, reg_max_load_o, reg_busy_o, mcu_clk_o, vhr_o;
  romc_mode_e mode_o;
  int fails = 0, checks = 0, n, tog;

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  romc_ctrl #(.WAKE_BASE_CYC(4)) uut (.clk_i(clk_i), .resetn_i(resetn_i),
    .supply_low_i(supply_low_i), .opctl_wr_i(opctl_wr_i), .opctl_data_i(opctl_data_i),
    .opctl_o(opctl_o), .mode_o(mode_o), .osc_en_o(osc_en_o), .osc_gm_boost_o(osc_gm_boost_o),
    .reg_en_o(reg_en_o), .rx_en_o(rx_en_o), .tx_en_o(tx_en_o), .osc_ampl_ok_i(osc_ampl_ok_i),
    .osc_irq_o(osc_irq_o), .osc_irq_clr_i(osc_irq_clr_i), .wake_irq_o(wake_irq_o),
    .wake_irq_clr_i(wake_irq_clr_i), .wake_period_i(wake_period_i), .cal_i(cal_i),
    .sense_thresh_i(sense_thresh_i), .meas_start_o(meas_start_o),
    .sense_patch_out_o(sense_patch_out_o), .meas_done_i(meas_done_i),
    .meas_value_i(meas_value_i), .ref_o(ref_o), .reg_adjust_i(reg_adjust_i),
    .vdd_level_i(vdd_level_i), .reg_max_load_o(reg_max_load_o), .reg_busy_o(reg_busy_o),
    .reg_manual_wr_i(reg_manual_wr_i), .reg_manual_val_i(reg_manual_val_i),
    .reg_ref_o(reg_ref_o), .reg_display_o(reg_display_o), .mcu_clk_sel_i(mcu_clk_sel_i),
    .mcu_clk_o(mcu_clk_o), .xtal_27m_i(xtal_27m_i), .very_high_rate_operation_ok_o(vhr_o));

  romc_meas_model #(.DELAY(3)) meas (.clk_i(clk_i), .start_i(meas_start_o),
    .value_i(mval), .done_o(meas_done_i), .value_o(meas_value_i));

  // ==========================================================
  // Access tasks
  task test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task wr_op(input logic [7:0] d);
    @(posedge clk_i);
    opctl_wr_i   <= 1'b1;
    opctl_data_i <= d;
    @(posedge clk_i);
    opctl_wr_i   <= 1'b0;
    cyc(1);
  endtask

  task pulse(input int sel);
    @(posedge clk_i);
    case (sel)
      0: cal_i <= 1'b1;
      1: reg_adjust_i <= 1'b1;
      default: reg_manual_wr_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {cal_i, reg_adjust_i, reg_manual_wr_i} <= 3'b000;
    cyc(1);
  endtask

  task wait_on(input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      cyc(1);
      if ((sel == 0 && osc_irq_o === 1'b1) || (sel == 1 && ref_o === 8'h30) ||
          (sel == 2 && wake_irq_o === 1'b1) || (sel == 3 && reg_busy_o === 1'b0)) break;
    end
    if (i == lim) begin
      fails++;
      $display("FAIL %0t wait %0d ran out", $time, sel);
      test_done();
    end
  endtask

  task count_clk(input logic [1:0] sel, input int lo, input int hi, input string what);
    logic prev;
    int   k;
    mcu_clk_sel_i <= sel;
    cyc(4);
    tog = 0;
    for (k = 0; k < 24; k++) begin
      prev = mcu_clk_o;
      cyc(1);
      if (mcu_clk_o !== prev) tog++;
    end
    cmp({7'h0, tog >= lo && tog <= hi}, 8'h01, what);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    cyc(4);
    resetn_i <= 1'b1;
    cyc(1);
    cmp(opctl_o, 8'h00, "reset word");
    cmp({6'h0, mode_o}, {6'h0, ROMC_POWER_DOWN}, "reset mode");
    cmp({3'h0, osc_en_o, reg_en_o, rx_en_o, tx_en_o, mcu_clk_o}, 8'h00, "reset enables");
    wr_op(8'h40);
    cmp({5'h0, osc_en_o, rx_en_o, tx_en_o}, 8'h02, "rx only");
    cmp({6'h0, mode_o}, {6'h0, ROMC_ACTIVE}, "rx only mode");
    wr_op(8'h08);
    cmp({5'h0, osc_en_o, rx_en_o, tx_en_o}, 8'h01, "tx only");
    mcu_clk_sel_i <= 2'h1;
    wr_op(8'h80);
    cmp({osc_en_o, reg_en_o, 6'h0}, 8'hc0, "ready enables");
    cmp({6'h0, mode_o}, {6'h0, ROMC_READY}, "ready mode");
    cyc(1);
    cmp({7'h0, osc_gm_boost_o}, 8'h01, "start boost");
    osc_ampl_ok_i <= 1'b1;
    wait_on(0, 60);
    cmp({7'h0, osc_gm_boost_o}, 8'h00, "boost off");
    count_clk(2'h1, 23, 24, "host clock half");
    count_clk(2'h2, 11, 13, "host clock quarter");
    count_clk(2'h3, 5, 7, "host clock eighth");
    count_clk(2'h0, 0, 0, "host clock stopped");
    cmp({7'h0, mcu_clk_o}, 8'h00, "host clock low");
    osc_irq_clr_i <= 1'b1;
    cyc(2);
    osc_irq_clr_i <= 1'b0;
    cyc(1);
    cmp({7'h0, osc_irq_o}, 8'h00, "osc irq cleared");
    wr_op(8'h04);
    cmp({6'h0, mode_o}, {6'h0, ROMC_WAKE_UP}, "wake mode");
    pulse(0);
    wait_on(1, 60);
    cmp({7'h0, wake_irq_o}, 8'h00, "no irq on cal");
    mval <= 8'h40;
    wake_period_i <= 3'h2;
    tog = 0;
    for (n = 0; n < 40; n++) begin
      cyc(1);
      if (sense_patch_out_o === 1'b1) tog++;
    end
    cmp({7'h0, tog >= 8 && tog <= 17}, 8'h01, "patch duty");
    cmp({7'h0, wake_irq_o}, 8'h00, "at threshold");
    mval <= 8'h41;
    wait_on(2, 60);
    wake_irq_clr_i <= 1'b1;
    wr_op(8'h00);
    wake_irq_clr_i <= 1'b0;
    tog = 0;
    for (n = 0; n < 40; n++) begin
      cyc(1);
      if (meas_start_o === 1'b1) tog++;
    end
    cmp(tog[7:0], 8'h00, "wake stopped");
    cmp({7'h0, wake_irq_o}, 8'h00, "wake irq cleared");
    cmp({7'h0, sense_patch_out_o}, 8'h00, "patch idle");
    pulse(1);
    cmp({6'h0, reg_busy_o, reg_max_load_o}, 8'h03, "adjust load");
    wait_on(3, 100);
    cyc(1);
    cmp(reg_ref_o, 8'h67, "adjust ref");
    cmp(reg_display_o, 8'h67, "adjust display");
    reg_manual_val_i <= 8'h55;
    pulse(2);
    cmp(reg_ref_o, 8'h55, "manual ref");
    cmp(reg_display_o, 8'h55, "manual display");
    xtal_27m_i <= 1'b1;
    wr_op(8'h80);
    cmp({7'h0, vhr_o}, 8'h01, "high rate crystal");
    supply_low_i <= 1'b1;
    cyc(6);
    cmp(opctl_o, 8'h00, "low supply reset");
    supply_low_i <= 1'b0;
    cyc(4);
    cmp({6'h0, mode_o}, {6'h0, ROMC_POWER_DOWN}, "mode after low supply");
    cmp({7'h0, osc_en_o}, 8'h00, "osc off after low supply");
    test_done();
  end
endmodule // test_romc_ctrl
